// ---- src/autoneg_defs.svh ----
`ifndef AUTONEG_DEFS_SVH
`define AUTONEG_DEFS_SVH

// register addresses
`define AN_REG_CTRL 5'h00
`define AN_REG_STAT 5'h01
`define AN_REG_ADV 5'h04
`define AN_REG_LPA 5'h05
`define AN_REG_EXP 5'h06
`define AN_REG_SUMM 5'h10

// control register fields
`define AN_CTRL_SPEED 13
`define AN_CTRL_ANEN 12
`define AN_CTRL_RESTART 9
`define AN_CTRL_DUPLEX 8
`define AN_CTRL_RESET 16'h1000
`define AN_CTRL_WMASK 16'h3100

// advertisement / partner fields
`define AN_ADV_PAUSE 10
`define AN_ADV_ABIL_HI 8
`define AN_ADV_ABIL_LO 5
`define AN_ADV_RESET 16'h01E1
`define AN_ADV_WMASK 16'h05E0
`define AN_ADV_SELECTOR 16'h0001
`define AN_LPA_NEXTPAGE 15
`define AN_LPA_REMFAULT 13
`define AN_LPA_PD_100 16'h0081
`define AN_LPA_PD_10 16'h0021

// status fields
`define AN_STAT_CONST 16'h7849
`define AN_STAT_COMPLETE 5
`define AN_STAT_REMFAULT 4
`define AN_STAT_LINK 2
`define AN_EXP_PDFAULT 4
`define AN_EXP_LP_NP 3
`define AN_EXP_PAGE 1
`define AN_EXP_LP_ABLE 0
`define AN_SUMM_LINK 0
`define AN_SUMM_SPEED10 1
`define AN_SUMM_DUPLEX 2
`define AN_SUMM_COMPLETE 4

// synchronised input indices
`define AN_PIN_LINK10 0
`define AN_PIN_LINK100 1
`define AN_PIN_STRAP_EN 2
`define AN_PIN_SEL_HI 3
`define AN_PIN_SEL_LO 4
`define AN_PIN_PAUSE 5
`define AN_PIN_COUNT 6

// timing
`define AN_CLK_HZ 25000000
`define AN_TICK_CYCLES (`AN_CLK_HZ / 1000)
`define AN_BREAK_LINK_MS 1500
`define AN_COMPLETE_MS 3000
`define AN_PD_SETTLE_MS 10
`define AN_STRAP_SETTLE 3'h4

`endif

// ---- src/autoneg_pkg.sv ----
package autoneg_pkg;

  typedef enum logic [1:0] {
    ST_FORCED,
    ST_BREAK,
    ST_ABILITY,
    ST_COMPLETE
  } an_state_t;

  typedef struct packed {
    logic speed100;
    logic fullDuplex;
  } link_mode_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wrData;
    logic write;
    logic read;
  } reg_req_t;

endpackage : autoneg_pkg

// ---- src/autoneg_config_control.sv ----
// How it works
// - straps at reset set advertisement bits 8:5
// - strap enable low forces mode from selects
// - strap enable high advertises strap-selected abilities
// - control writes override straps; selects never touch it
// - enabled negotiation sends advertisement word in bursts
// - summary speed/duplex valid when disabled or complete
// - best common mode, 100 full highest
// - control speed/duplex bits used only when disabled
// - status ability bits constant, T4 reads zero
// - status shows complete, fault, link, preamble
// - advertise all by default, writes clear abilities
// - partner register captures pages or detection value
// - parallel detection from both link receivers
// - detection sets bit 5/7, selector 00001
// - detection fault when both links good, or one good link not advertised
// - expansion shows fault, next pages, page, able
// - restart bit restarts negotiation
// - lost negotiated link resumes negotiation
// - renegotiation halts pulses for break-link timer
// - ability detect not complete within three seconds restarts negotiation
// - pause strap latched into advertisement at reset
`timescale 1ns/1ns
`include "autoneg_defs.svh"
module autoneg_config_control #(
  parameter int TICK_CYCLES = `AN_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic negotiationStrapEnable,
  input wire logic abilitySelectHigh,
  input wire logic abilitySelectLow,
  input wire logic pauseStrap,
  input wire logic link10Raw,
  input wire logic link100Raw,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  input wire autoneg_pkg::reg_req_t regReq,
  output logic [15:0] regRdData,
  output logic flpEnable,
  output logic [15:0] advertWord,
  output logic txHalt,
  output autoneg_pkg::link_mode_t linkMode,
  output logic negComplete,
  output logic linkUp
);

  // returns {ok, speed100, fullDuplex} for the best shared ability
  function automatic logic [2:0] resolveBest(input logic [3:0] common);
    logic [2:0] res;
    res = 3'h0;
    if (common[3])
      res = 3'h7;
    else if (common[2])
      res = 3'h6;
    else if (common[1])
      res = 3'h5;
    else if (common[0])
      res = 3'h4;
    return res;
  endfunction : resolveBest

  // input synchronisers: three stages, change accepted when 2nd and 3rd agree
  logic [`AN_PIN_COUNT-1:0] pinRaw;
  logic [`AN_PIN_COUNT-1:0] pinS1_r;
  logic [`AN_PIN_COUNT-1:0] pinS2_r;
  logic [`AN_PIN_COUNT-1:0] pinS3_r;
  logic [`AN_PIN_COUNT-1:0] pinFilt_r;

  assign pinRaw = {pauseStrap, abilitySelectLow, abilitySelectHigh,
                   negotiationStrapEnable, link100Raw, link10Raw};

  genvar gi;
  generate
    for (gi = 0; gi < `AN_PIN_COUNT; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pinS1_r[gi] <= 1'b0;
          pinS2_r[gi] <= 1'b0;
          pinS3_r[gi] <= 1'b0;
          pinFilt_r[gi] <= 1'b0;
        end
        else
        begin
          pinS1_r[gi] <= pinRaw[gi];
          pinS2_r[gi] <= pinS1_r[gi];
          pinS3_r[gi] <= pinS2_r[gi];
          if (pinS2_r[gi] == pinS3_r[gi])
            pinFilt_r[gi] <= pinS3_r[gi];
        end
      end
    end
  endgenerate

  wire link10 = pinFilt_r[`AN_PIN_LINK10];
  wire link100 = pinFilt_r[`AN_PIN_LINK100];
  wire strapEn = pinFilt_r[`AN_PIN_STRAP_EN];
  wire [1:0] strapSel = {pinFilt_r[`AN_PIN_SEL_HI], pinFilt_r[`AN_PIN_SEL_LO]};

  // straps are caught once the synchronisers have settled after reset release
  logic [2:0] settleCnt_r;
  logic strapDone_r;
  wire strapLoad = !strapDone_r && (settleCnt_r == `AN_STRAP_SETTLE);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      settleCnt_r <= 3'h0;
      strapDone_r <= 1'b0;
    end
    else
    begin
      if (settleCnt_r != `AN_STRAP_SETTLE)
        settleCnt_r <= settleCnt_r + 3'h1;
      if (strapLoad)
        strapDone_r <= 1'b1;
    end
  end

  // ability order in 4-bit vectors: {100F, 100H, 10F, 10H}
  wire [3:0] advNeg = (strapSel == 2'h0) ? 4'h3 :
                      (strapSel == 2'h1) ? 4'hC :
                      (strapSel == 2'h2) ? 4'h5 : 4'hF;
  wire [3:0] advForced = (strapSel == 2'h0) ? 4'h1 :
                         (strapSel == 2'h1) ? 4'h2 :
                         (strapSel == 2'h2) ? 4'h4 : 4'h8;
  wire [3:0] advStrap = strapEn ? advNeg : advForced;
  wire autoneg_pkg::link_mode_t strapMode = '{speed100: strapSel[1], fullDuplex: strapSel[0]};

  // register access decode
  wire wrCtrl = regReq.write && (regReq.addr == `AN_REG_CTRL);
  wire wrAdv = regReq.write && (regReq.addr == `AN_REG_ADV);
  wire rdExp = regReq.read && (regReq.addr == `AN_REG_EXP);
  wire restartReq = wrCtrl && regReq.wrData[`AN_CTRL_RESTART];

  logic [15:0] ctrl_r;
  logic armed_r;
  logic strapForce_r;
  logic [15:0] adv_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `AN_CTRL_RESET;
      armed_r <= 1'b1;
      strapForce_r <= 1'b0;
      adv_r <= `AN_ADV_RESET;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrl_r <= regReq.wrData & `AN_CTRL_WMASK;
        strapForce_r <= 1'b0;
        if (!regReq.wrData[`AN_CTRL_ANEN])
          armed_r <= 1'b1;
      end
      else if (strapLoad)
      begin
        ctrl_r[`AN_CTRL_ANEN] <= strapEn;
        armed_r <= strapEn;
        strapForce_r <= !strapEn;
      end
      if (wrAdv)
        adv_r <= (regReq.wrData & `AN_ADV_WMASK) | `AN_ADV_SELECTOR;
      else if (strapLoad)
      begin
        adv_r[`AN_ADV_ABIL_HI:`AN_ADV_ABIL_LO] <= advStrap;
        // pulled down strap advertises pause, floating does not
        adv_r[`AN_ADV_PAUSE] <= !pinFilt_r[`AN_PIN_PAUSE];
      end
    end
  end

  // a strapped forced device needs enable cleared then set before it negotiates
  wire anEnable = ctrl_r[`AN_CTRL_ANEN] && armed_r;
  wire autoneg_pkg::link_mode_t ctrlMode =
    '{speed100: ctrl_r[`AN_CTRL_SPEED], fullDuplex: ctrl_r[`AN_CTRL_DUPLEX]};
  wire autoneg_pkg::link_mode_t forcedMode = strapForce_r ? strapMode : ctrlMode;

  // millisecond tick shared by every timer
  logic [15:0] tickCnt_r;
  wire tick = (tickCnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tickCnt_r <= 16'h0;
    else
      tickCnt_r <= tick ? 16'h0 : tickCnt_r + 16'h1;
  end

  autoneg_pkg::an_state_t state_r;
  autoneg_pkg::an_state_t state_nxt;
  logic anEnPrev_r;
  logic [11:0] msCnt_r;
  logic [3:0] pdCnt_r;
  autoneg_pkg::link_mode_t mode_r;
  logic [15:0] partner_r;
  logic partnerAble_r;
  logic pageRcvd_r;
  logic pdFault_r;

  wire inAbility = (state_r == autoneg_pkg::ST_ABILITY);
  wire inComplete = (state_r == autoneg_pkg::ST_COMPLETE);
  wire inForced = (state_r == autoneg_pkg::ST_FORCED);
  // no rise counts before the straps are in, so a forced strap never starts a break
  wire enRise = anEnable && !anEnPrev_r && strapDone_r;

  wire [2:0] pageRes = resolveBest(adv_r[8:5] & pageWord[8:5]);
  wire pageOk = inAbility && pageValid && pageRes[2];

  wire oneGood = link10 ^ link100;
  wire bothGood = link10 && link100;
  // detection cannot see duplex, so the partner counts as half duplex
  wire [2:0] pdRes = resolveBest(adv_r[8:5] & (link100 ? 4'h4 : 4'h1));
  wire pdSettled = (pdCnt_r == 4'(`AN_PD_SETTLE_MS));
  wire pdOk = inAbility && !pageValid && !partnerAble_r && oneGood && pdSettled && pdRes[2];
  wire pdFaultSet = inAbility && !partnerAble_r && pdSettled
                    && (bothGood || (oneGood && !pdRes[2]));

  wire curLink = mode_r.speed100 ? link100 : link10;
  wire lostLink = inComplete && !curLink;
  wire breakDone = tick && (msCnt_r == 12'(`AN_BREAK_LINK_MS - 1));
  wire timeout = tick && (msCnt_r == 12'(`AN_COMPLETE_MS - 1));

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      autoneg_pkg::ST_FORCED:
        if (enRise)
          state_nxt = autoneg_pkg::ST_BREAK;
      autoneg_pkg::ST_BREAK:
        if (!anEnable)
          state_nxt = autoneg_pkg::ST_FORCED;
        else if (breakDone)
          state_nxt = autoneg_pkg::ST_ABILITY;
      autoneg_pkg::ST_ABILITY:
        if (!anEnable)
          state_nxt = autoneg_pkg::ST_FORCED;
        else if (restartReq || timeout)
          state_nxt = autoneg_pkg::ST_BREAK;
        else if (pageOk || pdOk)
          state_nxt = autoneg_pkg::ST_COMPLETE;
      autoneg_pkg::ST_COMPLETE:
        if (!anEnable)
          state_nxt = autoneg_pkg::ST_FORCED;
        else if (restartReq || lostLink)
          state_nxt = autoneg_pkg::ST_BREAK;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= autoneg_pkg::ST_FORCED;
      anEnPrev_r <= 1'b0;
      msCnt_r <= 12'h0;
      pdCnt_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      anEnPrev_r <= anEnable && strapDone_r;
      if (state_nxt != state_r)
        msCnt_r <= 12'h0;
      else if (tick)
        msCnt_r <= msCnt_r + 12'h1;
      if (!inAbility || !(oneGood || bothGood))
        pdCnt_r <= 4'h0;
      else if (tick && !pdSettled)
        pdCnt_r <= pdCnt_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= '0;
      partner_r <= 16'h0;
      partnerAble_r <= 1'b0;
      pageRcvd_r <= 1'b0;
      pdFault_r <= 1'b0;
    end
    else
    begin
      if (inForced)
        mode_r <= forcedMode;
      else if (pageOk)
        mode_r <= '{speed100: pageRes[1], fullDuplex: pageRes[0]};
      else if (pdOk)
        mode_r <= '{speed100: pdRes[1], fullDuplex: pdRes[0]};
      if (pageValid && (inAbility || inComplete))
      begin
        partner_r <= pageWord;
        partnerAble_r <= 1'b1;
      end
      else if (pdOk)
      begin
        partner_r <= link100 ? `AN_LPA_PD_100 : `AN_LPA_PD_10;
        partnerAble_r <= 1'b0;
      end
      else if (state_r == autoneg_pkg::ST_BREAK)
        partnerAble_r <= 1'b0;
      // a setting event in the read cycle wins over the clear
      if (pageValid && (inAbility || inComplete))
        pageRcvd_r <= 1'b1;
      else if (rdExp)
        pageRcvd_r <= 1'b0;
      if (pdFaultSet)
        pdFault_r <= 1'b1;
      else if (rdExp)
        pdFault_r <= 1'b0;
    end
  end

  // status views
  wire statLink = (inForced || inComplete) && curLink;
  wire remFault = partnerAble_r && partner_r[`AN_LPA_REMFAULT];
  wire [15:0] statWord = `AN_STAT_CONST
                         | (16'(inComplete) << `AN_STAT_COMPLETE)
                         | (16'(remFault) << `AN_STAT_REMFAULT)
                         | (16'(statLink) << `AN_STAT_LINK);
  wire [15:0] expWord = (16'(pdFault_r) << `AN_EXP_PDFAULT)
                        | (16'(partnerAble_r && partner_r[`AN_LPA_NEXTPAGE]) << `AN_EXP_LP_NP)
                        | (16'(pageRcvd_r) << `AN_EXP_PAGE)
                        | (16'(partnerAble_r) << `AN_EXP_LP_ABLE);
  wire modeValid = !anEnable || inComplete;
  wire [15:0] summWord = (16'(statLink) << `AN_SUMM_LINK)
                         | (16'(modeValid && !mode_r.speed100) << `AN_SUMM_SPEED10)
                         | (16'(modeValid && mode_r.fullDuplex) << `AN_SUMM_DUPLEX)
                         | (16'(inComplete) << `AN_SUMM_COMPLETE);

  wire [15:0] rdMux = (regReq.addr == `AN_REG_CTRL) ? ctrl_r :
                      (regReq.addr == `AN_REG_STAT) ? statWord :
                      (regReq.addr == `AN_REG_ADV) ? adv_r :
                      (regReq.addr == `AN_REG_LPA) ? partner_r :
                      (regReq.addr == `AN_REG_EXP) ? expWord :
                      (regReq.addr == `AN_REG_SUMM) ? summWord : 16'h0000;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      regRdData <= 16'h0;
    else if (regReq.read)
      regRdData <= rdMux;
  end

  assign flpEnable = inAbility;
  assign advertWord = adv_r;
  assign txHalt = (state_r == autoneg_pkg::ST_BREAK);
  assign linkMode = mode_r;
  assign negComplete = inComplete;
  assign linkUp = statLink;

endmodule : autoneg_config_control

// ---- sim/autoneg_config_control_props.sv ----
`timescale 1ns/1ns
`include "autoneg_defs.svh"
module autoneg_config_control_props #(
  parameter int TICK_CYCLES = 4
) (
  input logic core_clk,
  input logic rst,
  input logic negotiationStrapEnable,
  input logic abilitySelectHigh,
  input logic abilitySelectLow,
  input logic pauseStrap,
  input logic link10Raw,
  input logic link100Raw,
  input logic pageValid,
  input logic [15:0] pageWord,
  input autoneg_pkg::reg_req_t regReq,
  input logic [15:0] regRdData,
  input logic flpEnable,
  input logic [15:0] advertWord,
  input logic txHalt,
  input autoneg_pkg::link_mode_t linkMode,
  input logic negComplete,
  input logic linkUp
);
  // one tick of slack either side: a break may start anywhere inside a tick
  localparam int BREAK_MIN = (`AN_BREAK_LINK_MS - 1) * TICK_CYCLES;
  localparam int BREAK_MAX = (`AN_BREAK_LINK_MS + 1) * TICK_CYCLES;
  int haltCnt_r;
  wire rdStat = regReq.read && regReq.addr == `AN_REG_STAT;
  wire rdSumm = regReq.read && regReq.addr == `AN_REG_SUMM;
  wire wrCtrl = regReq.write && regReq.addr == `AN_REG_CTRL;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      haltCnt_r <= 0;
    else
      haltCnt_r <= txHalt ? haltCnt_r + 1 : 0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_status_constant:
    assert property (rdStat |=> regRdData[15:11] == 5'h0F && regRdData[3] && regRdData[0])
    else $error("status ability bits wrong");
  a_status_complete:
    assert property (rdStat |=> regRdData[5] == $past(negComplete) && regRdData[6])
    else $error("status complete bit wrong");
  a_summary_gated:
    assert property (rdSumm && (txHalt || flpEnable) |=> regRdData[2:1] == 2'h0)
    else $error("summary mode shown before completion");
  a_halt_quiet:
    assert property (txHalt |-> !flpEnable && !negComplete)
    else $error("activity during break");
  a_break_length:
    assert property ($fell(txHalt) |-> haltCnt_r >= BREAK_MIN && haltCnt_r <= BREAK_MAX)
    else $error("break length wrong");
  a_break_then_bursts:
    assert property ($fell(txHalt) |-> flpEnable)
    else $error("no bursts after break");
  a_best_common:
    assert property (flpEnable && pageValid && pageWord == 16'h01E1
      && advertWord[8:5] == 4'h5 |=> negComplete && linkMode == 2'h2)
    else $error("wrong resolved mode");
  a_restart_halts:
    assert property (wrCtrl && regReq.wrData[9] && regReq.wrData[12] && negComplete
      |-> ##[1:3] txHalt)
    else $error("restart ignored");
  a_lost_link:
    assert property (negComplete && $fell(linkUp) |-> ##[0:2] txHalt)
    else $error("lost link not renegotiated");
  a_forced_by_ctrl:
    assert property (wrCtrl && !regReq.wrData[12] |=> ##1
      linkMode == {$past(regReq.wrData[13], 2), $past(regReq.wrData[8], 2)})
    else $error("control mode not applied");
endmodule : autoneg_config_control_props
bind autoneg_config_control autoneg_config_control_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .core_clk(core_clk), .rst(rst), .negotiationStrapEnable(negotiationStrapEnable),
  .abilitySelectHigh(abilitySelectHigh), .abilitySelectLow(abilitySelectLow),
  .pauseStrap(pauseStrap), .link10Raw(link10Raw), .link100Raw(link100Raw),
  .pageValid(pageValid), .pageWord(pageWord), .regReq(regReq), .regRdData(regRdData),
  .flpEnable(flpEnable), .advertWord(advertWord), .txHalt(txHalt), .linkMode(linkMode),
  .negComplete(negComplete), .linkUp(linkUp));

// ---- sim/remote_partner.sv ----
`timescale 1ns/1ns
module remote_partner (
  input logic core_clk,
  input logic rst,
  input logic [1:0] mode,
  input logic flpEnable,
  output logic pageValid,
  output logic [15:0] pageWord,
  output logic link10Raw,
  output logic link100Raw
);
  // mode 0 silent, 1 forced 10 Mb/s, 2 both receivers good, 3 negotiates then runs 100
  logic sent;
  logic [3:0] holdCnt;
  assign link10Raw = mode == 2'h1 || mode == 2'h2;
  // a negotiating partner shows link before its page lands, else the mode is lost at once
  assign link100Raw = mode == 2'h2 || mode == 2'h3;
  always @(negedge core_clk)
  begin
    pageValid <= 1'b0;
    // the word means nothing between pages, so keep it moving
    pageWord <= ~pageWord;
    if (rst || mode != 2'h3 || !flpEnable)
      holdCnt <= 4'h0;
    else if (holdCnt != 4'hF)
      holdCnt <= holdCnt + 4'h1;
    if (rst)
    begin
      pageWord <= 16'h0000;
      sent <= 1'b0;
    end
    else if (mode != 2'h3)
      sent <= 1'b0;
    else if (holdCnt == 4'h8 && !sent)
    begin
      pageValid <= 1'b1;
      pageWord <= 16'h01E1;
      sent <= 1'b1;
    end
  end
endmodule : remote_partner

// ---- sim/autoneg_config_control_tb.sv ----
`timescale 1ns/1ns
`include "autoneg_defs.svh"
module autoneg_config_control_tb;
  localparam int TICK = 4;
  localparam int BREAK_WAIT = (`AN_BREAK_LINK_MS + 2) * TICK + 20;
  // {strap enable, select high, select low, pause strap, advertisement, forced mode}
  localparam logic [21:0] ROWS [8] = '{
    {4'h1, 16'h0000, 2'h0}, {4'h2, 16'h0000, 2'h1}, {4'h5, 16'h0000, 2'h2},
    {4'h6, 16'h0000, 2'h3}, {4'h9, 16'h0061, 2'h0}, {4'hA, 16'h0581, 2'h0},
    {4'hD, 16'h00A1, 2'h0}, {4'hE, 16'h05E1, 2'h0}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic negotiationStrapEnable = 1'b0;
  logic abilitySelectHigh = 1'b0;
  logic abilitySelectLow = 1'b0;
  logic pauseStrap = 1'b1;
  logic [1:0] partnerMode = 2'h0;
  autoneg_pkg::reg_req_t regReq = '0;
  logic link10Raw, link100Raw, pageValid, flpEnable, txHalt, negComplete, linkUp;
  logic [15:0] pageWord, regRdData, advertWord, rd;
  autoneg_pkg::link_mode_t linkMode;
  int n_fail = 0;
  int checked = 0;
  always #20 core_clk = ~core_clk;
  autoneg_config_control #(.TICK_CYCLES(TICK)) i_autoneg_config_control (
    .core_clk(core_clk), .rst(rst), .negotiationStrapEnable(negotiationStrapEnable),
    .abilitySelectHigh(abilitySelectHigh), .abilitySelectLow(abilitySelectLow),
    .pauseStrap(pauseStrap), .link10Raw(link10Raw), .link100Raw(link100Raw),
    .pageValid(pageValid), .pageWord(pageWord), .regReq(regReq), .regRdData(regRdData),
    .flpEnable(flpEnable), .advertWord(advertWord), .txHalt(txHalt), .linkMode(linkMode),
    .negComplete(negComplete), .linkUp(linkUp));
  remote_partner i_remote_partner (.core_clk(core_clk), .rst(rst), .mode(partnerMode),
    .flpEnable(flpEnable), .pageValid(pageValid), .pageWord(pageWord),
    .link10Raw(link10Raw), .link100Raw(link100Raw));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  function automatic logic pick(input int which);
    return which == 0 ? txHalt : (which == 1 ? flpEnable : negComplete);
  endfunction : pick
  task automatic waitSig(input int which, input int limit);
    int n;
    n = 0;
    while (pick(which) !== 1'b1 && n < limit)
    begin
      @(negedge core_clk);
      n++;
    end
    check("wait flag", 16'h0001, {15'h0000, pick(which)});
    if (pick(which) !== 1'b1)
      summarize();
  endtask : waitSig
  task automatic doReset;
    rst = 1'b1;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    // straps are caught on the fifth edge after release
    repeat (6) @(negedge core_clk);
  endtask : doReset
  task automatic regWrite(input logic [4:0] a, input logic [15:0] d);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.write = 1'b1;
    @(negedge core_clk);
    regReq.write = 1'b0;
    @(negedge core_clk);
  endtask : regWrite
  task automatic regRead(input logic [4:0] a, output logic [15:0] d);
    regReq.addr = a;
    regReq.read = 1'b1;
    @(negedge core_clk);
    regReq.read = 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask : regRead
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      {negotiationStrapEnable, abilitySelectHigh, abilitySelectLow, pauseStrap} = ROWS[i][21:18];
      doReset();
      regRead(`AN_REG_CTRL, rd);
      check("control", {3'h0, ROWS[i][21], 12'h000}, rd);
      if (ROWS[i][21])
      begin
        regRead(`AN_REG_ADV, rd);
        check("advertisement", ROWS[i][17:2], rd);
      end
      else
        check("forced mode", {14'h0000, ROWS[i][1:0]}, {14'h0000, linkMode});
    end
    {negotiationStrapEnable, abilitySelectHigh, abilitySelectLow, pauseStrap} = 4'h7;
    doReset();
    regRead(5'h02, rd);
    check("unmapped", 16'h0000, rd);
    regRead(`AN_REG_STAT, rd);
    check("status", 16'h7849, rd & 16'hF849);
    regRead(`AN_REG_SUMM, rd);
    check("summary", 16'h0004, rd & 16'h0006);
    regWrite(`AN_REG_CTRL, 16'h0100);
    check("control mode", 16'h0001, {14'h0000, linkMode});
    regWrite(`AN_REG_LPA, 16'hFFFF);
    regRead(`AN_REG_LPA, rd);
    check("partner read only", 16'h0000, rd);
    regWrite(`AN_REG_ADV, 16'hFFFF);
    regRead(`AN_REG_ADV, rd);
    check("adv mask", 16'h05E1, rd);
    regWrite(`AN_REG_ADV, 16'h00A0);
    regRead(`AN_REG_ADV, rd);
    check("adv cleared", 16'h00A1, rd);
    regWrite(`AN_REG_CTRL, 16'h1000);
    waitSig(0, 10);
    waitSig(1, BREAK_WAIT);
    check("advert word", 16'h00A1, advertWord);
    partnerMode = 2'h3;
    waitSig(2, 50);
    check("resolved", 16'h0002, {14'h0000, linkMode});
    regRead(`AN_REG_LPA, rd);
    check("partner page", 16'h01E1, rd);
    regRead(`AN_REG_EXP, rd);
    check("expansion", 16'h0003, rd & 16'h001B);
    regWrite(`AN_REG_CTRL, 16'h1200);
    waitSig(0, 10);
    partnerMode = 2'h1;
    regRead(`AN_REG_SUMM, rd);
    check("summary in break", 16'h0000, rd & 16'h0006);
    waitSig(1, BREAK_WAIT);
    waitSig(2, 15 * TICK + 20);
    regRead(`AN_REG_LPA, rd);
    check("detected partner", 16'h0021, rd);
    regRead(`AN_REG_EXP, rd);
    check("detected not able", 16'h0000, rd & 16'h0011);
    check("detected mode", 16'h0000, {14'h0000, linkMode});
    partnerMode = 2'h0;
    waitSig(0, 20);
    partnerMode = 2'h2;
    waitSig(1, BREAK_WAIT);
    repeat (15 * TICK) @(negedge core_clk);
    regRead(`AN_REG_EXP, rd);
    check("detect fault", 16'h0010, rd & 16'h0010);
    summarize();
  end
endmodule : autoneg_config_control_tb
